// File: pkg/pid_valve_pkg.sv
/*
 * Constants for the valve loop controller: widths, register offsets,
 * control bit positions, reset values and the update timing.
 * Assumes a 10 MHz core clock and a classic Wishbone register bus.
 */
package pid_valve_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADC_W  = 12;
    localparam int REG_W  = 16;
    localparam int ERR_W  = 18;
    localparam int SUM_W  = 40;
    localparam int FRAC_W = 8;
    localparam int ADR_W  = 8;
    localparam int CNT_W  = 16;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 10_000_000;
    localparam int UPDATE_HZ     = 1000;
    localparam int UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_COMMAND  = 8'h04;
    localparam logic [7:0] OFS_KP       = 8'h08;
    localparam logic [7:0] OFS_KI       = 8'h0C;
    localparam logic [7:0] OFS_KD       = 8'h10;
    localparam logic [7:0] OFS_KF       = 8'h14;
    localparam logic [7:0] OFS_WINDOW   = 8'h18;
    localparam logic [7:0] OFS_DB_A     = 8'h1C;
    localparam logic [7:0] OFS_DB_B     = 8'h20;
    localparam logic [7:0] OFS_FEEDBACK = 8'h24;
    localparam logic [7:0] OFS_DRIVE    = 8'h28;
    localparam logic [7:0] OFS_INTEG    = 8'h2C;

    // ------------------------------------------------------------
    // Control fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_COEFFICIENT_PARAM_RANGE_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [15:0] PARAM_RST = 16'h0000;

    // ------------------------------------------------------------
    // Drive range
    // ------------------------------------------------------------
    localparam logic signed [SUM_W-1:0] DRV_MAX = 40'sh00_0000_7FFF;
    localparam logic signed [SUM_W-1:0] DRV_MIN = -40'sh00_0000_8000;

endpackage : pid_valve_pkg

// File: hw/pid_valve_loop_controller.sv
/*
 * PID valve loop controller with feedforward and dead-band offsets.
 * Assumes a 12-bit converter sample arriving asynchronously, a classic
 * Wishbone master, and a valve amplifier taking a signed 16-bit drive.
 */
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
// Notes on behaviour
// - Drive refreshed once every millisecond
// - Feedback sampled as twelve-bit converter value
// - Output sums P, I, D terms
// - Proportional term: gain times command minus feedback
// - Integrator accumulates error each update
// - Integrate only inside window; zero disables
// - Derivative of feedback, signed gain damps
// - Separate dead-band magnitudes for sides A, B
// - Nonzero command adds side dead-band offset
// - Feedforward adds bypass gain times command
// - Coefficients writable only in coefficient_param_range range
`timescale 1ns/1ps

module pid_valve_loop_controller #(
    parameter int UPDATE_CYCLES = pid_valve_pkg::UPDATE_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Converter sample
    input  wire logic [11:0] adc_sample,
    // Valve drive
    output logic      [15:0] drive_value,
    output logic             drive_update
);

    typedef enum logic [1:0] {ST_IDLE, ST_MULT, ST_INTEG, ST_DRIVE} loop_state_t;

    localparam int SW = pid_valve_pkg::SUM_W;
    localparam int FW = pid_valve_pkg::FRAC_W;
    localparam logic [pid_valve_pkg::CNT_W-1:0] TICK_LAST =
        pid_valve_pkg::CNT_W'(UPDATE_CYCLES - 1);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [15:0]          ctrl_q;
    logic [15:0]          command_q;
    logic [15:0]          kp_q;
    logic [15:0]          ki_q;
    logic [15:0]          kd_q;
    logic [15:0]          kf_q;
    logic [15:0]          window_q;
    logic [15:0]          db_a_q;
    logic [15:0]          db_b_q;
    logic                 ack_q;
    logic [31:0]          rdata_q;
    logic [11:0]          adc_meta_q;
    logic [11:0]          adc_sync_q;
    logic [15:0]          tick_cnt_q;
    logic                 tick_q;
    loop_state_t          state_q;
    logic signed [17:0]   fb_q;
    logic signed [17:0]   fb_prev_q;
    logic signed [17:0]   err_q;
    logic signed [SW-1:0] p_term_q;
    logic signed [SW-1:0] i_inc_q;
    logic signed [SW-1:0] d_term_q;
    logic signed [SW-1:0] f_term_q;
    logic signed [SW-1:0] db_term_q;
    logic                 in_window_q;
    logic signed [SW-1:0] integ_q;
    logic [15:0]          drive_q;
    logic                 drive_upd_q;
    logic                 bus_req;
    logic                 bus_wr;
    logic                 coefficient_param_range;
    logic                 enable;
    logic signed [17:0]   fb_now;
    logic [17:0]          err_abs;
    logic signed [SW-1:0] sum_all;
    logic signed [SW-1:0] integ_next;

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign bus_wr  = bus_req & wb_we_i;
    assign coefficient_param_range  = ctrl_q[pid_valve_pkg::CTRL_COEFFICIENT_PARAM_RANGE_BIT];
    assign enable  = ctrl_q[pid_valve_pkg::CTRL_ENABLE_BIT];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        logic [15:0] v;
        v = old_v;
        if (sel[0])
        begin
            v[7:0] = dat[7:0];
        end
        if (sel[1])
        begin
            v[15:8] = dat[15:8];
        end
        return v;
    endfunction : merge16

    function automatic logic signed [SW-1:0] clamp(input logic signed [SW-1:0] v);
        if (v > pid_valve_pkg::DRV_MAX)
        begin
            return pid_valve_pkg::DRV_MAX;
        end
        else if (v < pid_valve_pkg::DRV_MIN)
        begin
            return pid_valve_pkg::DRV_MIN;
        end
        return v;
    endfunction : clamp

    // ------------------------------------------------------------
    // Wishbone handshake
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= bus_req;
        end
    end

    // ------------------------------------------------------------
    // Basic range registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q    <= pid_valve_pkg::CTRL_RST;
            command_q <= pid_valve_pkg::PARAM_RST;
            db_a_q    <= pid_valve_pkg::PARAM_RST;
            db_b_q    <= pid_valve_pkg::PARAM_RST;
        end
        else if (bus_wr)
        begin
            case (wb_adr_i)
                pid_valve_pkg::OFS_CTRL:    ctrl_q    <= merge16(ctrl_q, wb_dat_i, wb_sel_i);
                pid_valve_pkg::OFS_COMMAND: command_q <= merge16(command_q, wb_dat_i, wb_sel_i);
                pid_valve_pkg::OFS_DB_A:    db_a_q    <= merge16(db_a_q, wb_dat_i, wb_sel_i);
                pid_valve_pkg::OFS_DB_B:    db_b_q    <= merge16(db_b_q, wb_dat_i, wb_sel_i);
                default:                    ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Coefficient_param_range range registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            kp_q     <= pid_valve_pkg::PARAM_RST;
            ki_q     <= pid_valve_pkg::PARAM_RST;
            kd_q     <= pid_valve_pkg::PARAM_RST;
            kf_q     <= pid_valve_pkg::PARAM_RST;
            window_q <= pid_valve_pkg::PARAM_RST;
        end
        else if (bus_wr && coefficient_param_range)
        begin
            case (wb_adr_i)
                pid_valve_pkg::OFS_KP:     kp_q     <= merge16(kp_q, wb_dat_i, wb_sel_i);
                pid_valve_pkg::OFS_KI:     ki_q     <= merge16(ki_q, wb_dat_i, wb_sel_i);
                pid_valve_pkg::OFS_KD:     kd_q     <= merge16(kd_q, wb_dat_i, wb_sel_i);
                pid_valve_pkg::OFS_KF:     kf_q     <= merge16(kf_q, wb_dat_i, wb_sel_i);
                pid_valve_pkg::OFS_WINDOW: window_q <= merge16(window_q, wb_dat_i, wb_sel_i);
                default:                   ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (bus_req && !wb_we_i)
        begin
            case (wb_adr_i)
                pid_valve_pkg::OFS_CTRL:     rdata_q <= {16'h0000, ctrl_q};
                pid_valve_pkg::OFS_COMMAND:  rdata_q <= {16'h0000, command_q};
                pid_valve_pkg::OFS_KP:       rdata_q <= {16'h0000, kp_q};
                pid_valve_pkg::OFS_KI:       rdata_q <= {16'h0000, ki_q};
                pid_valve_pkg::OFS_KD:       rdata_q <= {16'h0000, kd_q};
                pid_valve_pkg::OFS_KF:       rdata_q <= {16'h0000, kf_q};
                pid_valve_pkg::OFS_WINDOW:   rdata_q <= {16'h0000, window_q};
                pid_valve_pkg::OFS_DB_A:     rdata_q <= {16'h0000, db_a_q};
                pid_valve_pkg::OFS_DB_B:     rdata_q <= {16'h0000, db_b_q};
                pid_valve_pkg::OFS_FEEDBACK: rdata_q <= {20'h0_0000, adc_sync_q};
                pid_valve_pkg::OFS_DRIVE:    rdata_q <= {16'h0000, drive_q};
                pid_valve_pkg::OFS_INTEG:    rdata_q <= {16'h0000, integ_q[15:0]};
                default:                     rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Converter synchroniser
    // ------------------------------------------------------------
    // Twelve-bit feedback
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            adc_meta_q <= 12'h000;
            adc_sync_q <= 12'h000;
        end
        else
        begin
            adc_meta_q <= adc_sample;
            adc_sync_q <= adc_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Update tick
    // ------------------------------------------------------------
    // Millisecond update tick
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end
        else if (tick_cnt_q == TICK_LAST)
        begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            tick_q     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:  state_q <= tick_q ? ST_MULT : ST_IDLE;
                ST_MULT:  state_q <= ST_INTEG;
                ST_INTEG: state_q <= ST_DRIVE;
                ST_DRIVE: state_q <= ST_IDLE;
                default:  state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Term products
    // ------------------------------------------------------------
    assign fb_now  = $signed({6'h00, adc_sync_q});
    assign err_abs = err_q[17] ? 18'(-err_q) : 18'(err_q);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fb_q      <= 18'sh0_0000;
            fb_prev_q <= 18'sh0_0000;
            err_q     <= 18'sh0_0000;
            p_term_q  <= '0;
            i_inc_q   <= '0;
            d_term_q  <= '0;
            f_term_q  <= '0;
            db_term_q <= '0;
        end
        else if (state_q == ST_IDLE && tick_q)
        begin
            fb_q      <= fb_now;
            fb_prev_q <= fb_q;
            err_q     <= 18'($signed(command_q) - fb_now);
        end
        else if (state_q == ST_MULT)
        begin
            p_term_q  <= ($signed(kp_q) * err_q) >>> FW;
            i_inc_q   <= ($signed(ki_q) * err_q) >>> FW;
            d_term_q  <= ($signed(kd_q) * 18'(fb_prev_q - fb_q)) >>> FW;
            f_term_q  <= ($signed(kf_q) * $signed(command_q)) >>> FW;
            if (command_q == 16'h0000)
            begin
                db_term_q <= '0;
            end
            else if (command_q[15])
            begin
                db_term_q <= -$signed({24'h00_0000, db_b_q});
            end
            else
            begin
                db_term_q <= $signed({24'h00_0000, db_a_q});
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            in_window_q <= 1'b0;
        end
        else if (state_q == ST_MULT)
        begin
            in_window_q <= (window_q != 16'h0000) && (err_abs <= {2'b00, window_q});
        end
    end

    // ------------------------------------------------------------
    // Integrator
    // ------------------------------------------------------------
    // Anti-windup clamp
    assign integ_next = clamp(integ_q + i_inc_q);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            integ_q <= '0;
        end
        else if (!enable || window_q == 16'h0000)
        begin
            integ_q <= '0;
        end
        else if (state_q == ST_INTEG && in_window_q)
        begin
            integ_q <= integ_next;
        end
    end

    // ------------------------------------------------------------
    // Output sum
    // ------------------------------------------------------------
    // Sum of all terms
    assign sum_all = p_term_q + integ_q + d_term_q + f_term_q + db_term_q;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            drive_q     <= 16'h0000;
            drive_upd_q <= 1'b0;
        end
        else if (state_q == ST_DRIVE)
        begin
            drive_q     <= enable ? 16'(clamp(sum_all)) : 16'h0000;
            drive_upd_q <= 1'b1;
        end
        else
        begin
            drive_upd_q <= 1'b0;
        end
    end

    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = rdata_q;
    assign drive_value  = drive_q;
    assign drive_update = drive_upd_q;

endmodule : pid_valve_loop_controller

// File: testbench/pid_valve_loop_controller_properties.sv
/* Port checker for the valve loop controller, bound to it below.
   Assumes one clock domain and classic Wishbone traffic. */
`timescale 1ns/1ps
module pid_valve_loop_controller_properties #(
    parameter int UPDATE_CYCLES = 16
) (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Drive
    input wire logic [15:0] drive_value,
    input wire logic        drive_update
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // --------------------------------
    // Helper state
    // --------------------------------
    logic [15:0] gap_q;
    logic        seen_q;
    logic        xp_q;
    logic        en_q;
    logic        kpz_q;
    logic        wr;
    logic        rdk;
    assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rdk = wb_ack_o && !wb_we_i;
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gap_q  <= 16'h0000;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q  <= drive_update ? 16'h0000 : gap_q + 16'h0001;
            seen_q <= seen_q | drive_update;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xp_q  <= 1'b0;
            en_q  <= 1'b0;
            kpz_q <= 1'b1;
        end
        else if (wr && wb_adr_i == pid_valve_pkg::OFS_CTRL && wb_sel_i[0])
        begin
            xp_q <= wb_dat_i[0];
            en_q <= wb_dat_i[1];
        end
        else if (wr && wb_adr_i == pid_valve_pkg::OFS_KP && xp_q && |wb_sel_i[1:0])
        begin
            kpz_q <= 1'b0;
        end
    end
    // --------------------------------
    // Properties
    // --------------------------------
    property p_period; drive_update && seen_q |-> gap_q == 16'(UPDATE_CYCLES - 1); endproperty
    a_period: assert property (p_period) else $error("update spacing wrong");
    property p_hold; $changed(drive_value) |-> drive_update; endproperty
    a_hold: assert property (p_hold) else $error("drive moved without update");
    property p_off; drive_update && !en_q && !$past(en_q, 5) |-> drive_value == 16'h0000; endproperty
    a_off: assert property (p_off) else $error("drive nonzero while disabled");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_hi_zero; rdk |-> wb_dat_o[31:16] == 16'h0000; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
    property p_unmapped; rdk && wb_adr_i > 8'h2C |-> wb_dat_o == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_fb_width; rdk && wb_adr_i == pid_valve_pkg::OFS_FEEDBACK |-> wb_dat_o[15:12] == 4'h0;
    endproperty
    a_fb_width: assert property (p_fb_width) else $error("feedback wider than 12 bits");
    property p_lock; rdk && wb_adr_i == pid_valve_pkg::OFS_KP && kpz_q |-> wb_dat_o == 32'h0; endproperty
    a_lock: assert property (p_lock) else $error("gain written outside coefficient_param_range");
endmodule : pid_valve_loop_controller_properties

bind pid_valve_loop_controller pid_valve_loop_controller_properties #(
    .UPDATE_CYCLES(UPDATE_CYCLES)
) pid_valve_loop_controller_properties_i (
    .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .drive_value(drive_value),
    .drive_update(drive_update)
);

// File: testbench/transducer_model.sv
/* Feedback transducer model: position to converter sample.
   Assumes positions given in converter counts; LAG sets its speed. */
`timescale 1ns/1ps
module transducer_model #(
    parameter int LAG = 1
) (
    // Clock
    input  wire logic        core_clk,
    // Position and sample
    input  wire logic [11:0] position,
    output logic      [11:0] adc_sample
);
    logic [11:0] pipe_q [LAG] = '{default: 12'h000};
    always @(posedge core_clk)
    begin
        pipe_q[0] <= position;
        for (int i = 1; i < LAG; i++) pipe_q[i] <= pipe_q[i-1];
    end
    assign adc_sample = pipe_q[LAG-1];
endmodule : transducer_model

// File: testbench/tb_pid_valve_loop_controller.sv
/* Self-checking bench for the valve loop controller.
   Assumes a short update period and a three-cycle transducer. */
`timescale 1ns/1ps
module tb_pid_valve_loop_controller;
    localparam int UC = 64;
    logic        core_clk = 1'b0;
    logic        reset_n  = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [11:0] position = 12'h000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [11:0] adc_sample;
    logic [15:0] drive_value;
    logic        drive_update;
    int          fails = 0;
    int          checks_done = 0;
    int          cyc_cnt = 0;
    logic [15:0] exp_drv[$];
    logic [15:0] exp_rd[$];
    logic [15:0] last = 16'h0000;
    logic [15:0] dbc[3] = '{16'h012C, 16'hFED4, 16'h0000};
    longint      cmd = 0, fb = 0, fbp = 0, kp = 0, ki = 0, kd = 0;
    longint      kf = 0, win = 0, dba = 0, dbb = 0, acc = 0;
    bit          xp = 0, en = 0;

    pid_valve_loop_controller #(.UPDATE_CYCLES(UC)) pid_valve_loop_controller_i (
        .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_sample(adc_sample),
        .drive_value(drive_value), .drive_update(drive_update)
    );
    transducer_model #(.LAG(3)) transducer_model_i (
        .core_clk(core_clk), .position(position), .adc_sample(adc_sample)
    );

    always #50 core_clk = ~core_clk;

    // --------------------------------
    // Reference model and tasks
    // --------------------------------
    function automatic longint sat(input longint v);
        return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    endfunction : sat
    function automatic logic [15:0] mdl();
        longint e;
        longint s;
        e = cmd - fb;
        if (win == 0 || !en)
            acc = 0;
        else if ((e < 0 ? -e : e) <= win)
            acc = sat(acc + ((ki * e) >>> 8));
        s = ((kp * e) >>> 8) + acc + ((kd * (fbp - fb)) >>> 8) + ((kf * cmd) >>> 8);
        s = s + (cmd > 0 ? dba : (cmd < 0 ? -dbb : 0));
        fbp = fb;
        return en ? 16'(sat(s)) : 16'h0000;
    endfunction : mdl
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic conclude();
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0000, d};
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask : wb
    task automatic set(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a, d);
        case (a)
            pid_valve_pkg::OFS_CTRL:    {en, xp} = d[1:0];
            pid_valve_pkg::OFS_COMMAND: cmd = longint'($signed(d));
            pid_valve_pkg::OFS_DB_A:    dba = longint'(d);
            pid_valve_pkg::OFS_DB_B:    dbb = longint'(d);
            default: ;
        endcase
        if (xp)
            case (a)
                pid_valve_pkg::OFS_KP:     kp = longint'($signed(d));
                pid_valve_pkg::OFS_KI:     ki = longint'($signed(d));
                pid_valve_pkg::OFS_KD:     kd = longint'($signed(d));
                pid_valve_pkg::OFS_KF:     kf = longint'($signed(d));
                pid_valve_pkg::OFS_WINDOW: win = longint'(d);
                default: ;
            endcase
    endtask : set
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_rd.push_back(e);
        wb(1'b0, a, 16'h0000);
    endtask : rd
    task automatic put(input logic [11:0] p);
        position <= p;
        fb = longint'(p);
    endtask : put
    task automatic step(input int n);
        repeat (n)
        begin
            last = mdl();
            exp_drv.push_back(last);
            do @(posedge core_clk); while (drive_update !== 1'b1);
        end
    endtask : step

    // --------------------------------
    // Monitor and watchdog
    // --------------------------------
    always @(posedge core_clk)
    begin
        if (drive_update === 1'b1) cmp({16'h0, drive_value}, {16'h0, exp_drv.pop_front()});
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) cmp(wb_dat_o, {16'h0, exp_rd.pop_front()});
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000)
        begin
            fails++;
            conclude();
        end
    end

    initial
    begin
        void'($urandom(32'h96942196));
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(pid_valve_pkg::OFS_CTRL, 16'h0000);
        set(pid_valve_pkg::OFS_KP, 16'h0100);
        rd(pid_valve_pkg::OFS_KP, 16'h0000);
        rd(8'h3C, 16'h0000);
        step(2);
        set(pid_valve_pkg::OFS_CTRL, 16'h0003);
        set(pid_valve_pkg::OFS_KP, 16'h0100);
        rd(pid_valve_pkg::OFS_KP, 16'h0100);
        put(12'h0C8);
        set(pid_valve_pkg::OFS_COMMAND, 16'h03E8);
        step(1);
        repeat (4)
        begin
            set(pid_valve_pkg::OFS_KP, 16'($urandom));
            set(pid_valve_pkg::OFS_COMMAND, 16'($urandom));
            put(12'($urandom));
            step(1);
        end
        set(pid_valve_pkg::OFS_KP, 16'h0000);
        set(pid_valve_pkg::OFS_DB_A, 16'h0032);
        set(pid_valve_pkg::OFS_DB_B, 16'h0046);
        foreach (dbc[i])
        begin
            set(pid_valve_pkg::OFS_COMMAND, dbc[i]);
            step(1);
        end
        set(pid_valve_pkg::OFS_KF, 16'h0080);
        set(pid_valve_pkg::OFS_COMMAND, 16'hFC18);
        step(1);
        set(pid_valve_pkg::OFS_KF, 16'h0000);
        set(pid_valve_pkg::OFS_KI, 16'h0100);
        set(pid_valve_pkg::OFS_WINDOW, 16'h0010);
        put(12'h100);
        set(pid_valve_pkg::OFS_COMMAND, 16'h010A);
        step(3);
        set(pid_valve_pkg::OFS_COMMAND, 16'h0164);
        step(1);
        rd(pid_valve_pkg::OFS_INTEG, 16'h001E);
        set(pid_valve_pkg::OFS_WINDOW, 16'h0000);
        step(1);
        set(pid_valve_pkg::OFS_KD, 16'h0200);
        put(12'h064);
        step(1);
        put(12'h096);
        step(1);
        set(pid_valve_pkg::OFS_KD, 16'hFE00);
        put(12'h064);
        step(1);
        rd(pid_valve_pkg::OFS_FEEDBACK, 16'h0064);
        set(pid_valve_pkg::OFS_FEEDBACK, 16'h0ABC);
        rd(pid_valve_pkg::OFS_FEEDBACK, 16'h0064);
        set(pid_valve_pkg::OFS_KD, 16'h0000);
        set(pid_valve_pkg::OFS_KI, 16'h7FFF);
        set(pid_valve_pkg::OFS_WINDOW, 16'hFFFF);
        put(12'h000);
        set(pid_valve_pkg::OFS_COMMAND, 16'h0FA0);
        step(2);
        rd(pid_valve_pkg::OFS_INTEG, 16'h7FFF);
        put(12'hFFF);
        set(pid_valve_pkg::OFS_COMMAND, 16'hF060);
        step(1);
        rd(pid_valve_pkg::OFS_INTEG, 16'h8000);
        rd(pid_valve_pkg::OFS_DRIVE, last);
        set(pid_valve_pkg::OFS_CTRL, 16'h0002);
        set(pid_valve_pkg::OFS_KI, 16'h0001);
        rd(pid_valve_pkg::OFS_KI, 16'h7FFF);
        set(pid_valve_pkg::OFS_CTRL, 16'h0000);
        step(1);
        rd(pid_valve_pkg::OFS_INTEG, 16'h0000);
        conclude();
    end
endmodule : tb_pid_valve_loop_controller
